// ---- hdl/adc_conversion_options.sv ----
/*
 * ADC conversion sequencer with averaging, attenuator bypass,
 * single-channel mode and cycle timing, plus its option registers.
 * Assumes an on-chip converter on SYS_CLK that holds a valid
 * ADC_CODE by the end of each sample period, and a register port
 * on the same clock.
 */
`timescale 1ns/1ps

`include "adc_opt_defines.svh"

module adc_conversion_options
    import adc_opt_pkg::*;
#(
    parameter int unsigned VOLT_CYC   = `T_VOLT_US * `CLK_MHZ,
    parameter int unsigned LOCAL_CYC  = `T_LOCAL_US * `CLK_MHZ,
    parameter int unsigned REMOTE_CYC = `T_REMOTE_US * `CLK_MHZ,
    parameter int unsigned CYCLE_CYC  = `T_CYCLE_US * `CLK_MHZ,
    parameter int unsigned SLOW_CYC   = `T_SLOW_US * `CLK_MHZ
) (
    input  wire logic       SYS_CLK,       // 20 MHz clock
    input  wire logic       RST_N,         // async reset, low
    input  wire logic [7:0] REG_ADDR,      // register offset
    input  wire logic [7:0] REG_WDATA,     // write data
    input  wire logic       REG_WR,        // write strobe
    input  wire logic       REG_RD,        // read strobe
    output logic      [7:0] REG_RDATA,     // read data
    input  wire logic [9:0] ADC_CODE,      // converter result
    output logic            ADC_START,     // sample start pulse
    output logic      [3:0] ADC_CHAN,      // mux channel
    output logic      [4:0] GLOBAL_ATTENUATOR_BYPASS_BYPASS,   // attenuator bypass
    output logic            RES_VALID,     // result strobe
    output logic      [3:0] RES_CHAN,      // result channel
    output logic      [9:0] RES_CODE,      // result code
    output logic      [7:0] TACH_MIN_HIGH  // fan limit high byte
);

    localparam tick_t VOLT_T   = tick_t'(VOLT_CYC - 1);
    localparam tick_t LOCAL_T  = tick_t'(LOCAL_CYC - 1);
    localparam tick_t REMOTE_T = tick_t'(REMOTE_CYC - 1);
    localparam tick_t CYCLE_T  = tick_t'(CYCLE_CYC - 1);
    localparam tick_t SLOW_T   = tick_t'(SLOW_CYC - 1);

    logic [7:0] cfg6_ff;
    logic [7:0] nxt_cfg6;
    logic [7:0] tach_ff;
    logic [7:0] nxt_tach;
    logic [7:0] cfg2_ff;
    logic [7:0] nxt_cfg2;
    logic [7:0] cfg4_ff;
    logic [7:0] nxt_cfg4;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    // register file
    always_comb begin
        nxt_cfg6  = cfg6_ff;
        nxt_tach  = tach_ff;
        nxt_cfg2  = cfg2_ff;
        nxt_cfg4  = cfg4_ff;
        nxt_rdata = rdata_ff;
        if (REG_WR) begin
            unique case (REG_ADDR)
                `ADDR_CFG6: begin
                    nxt_cfg6 = REG_WDATA;
                end
                `ADDR_TACH_SEL: begin
                    nxt_tach = REG_WDATA;
                end
                `ADDR_CFG2: begin
                    nxt_cfg2 = REG_WDATA;
                end
                `ADDR_CFG4: begin
                    nxt_cfg4 = REG_WDATA;
                end
                default: begin
                end
            endcase
        end
        if (REG_RD) begin
            unique case (REG_ADDR)
                `ADDR_CFG6: begin
                    nxt_rdata = cfg6_ff;
                end
                `ADDR_TACH_SEL: begin
                    nxt_rdata = tach_ff;
                end
                `ADDR_CFG2: begin
                    nxt_rdata = cfg2_ff;
                end
                `ADDR_CFG4: begin
                    nxt_rdata = cfg4_ff;
                end
                default: begin
                    nxt_rdata = `UNMAPPED_READ;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg6_ff  <= `REG_RESET;
            tach_ff  <= `REG_RESET;
            cfg2_ff  <= `REG_RESET;
            cfg4_ff  <= `REG_RESET;
            rdata_ff <= `REG_RESET;
        end else begin
            cfg6_ff  <= nxt_cfg6;
            tach_ff  <= nxt_tach;
            cfg2_ff  <= nxt_cfg2;
            cfg4_ff  <= nxt_cfg4;
            rdata_ff <= nxt_rdata;
        end
    end

    logic  avg_off;
    logic  gbyp;
    logic  single;
    logic  slow;
    chan_t sel_chan;

    // option bits decoded from the config registers
    assign avg_off  = cfg2_ff[`CFG2_AVG_OFF_BIT];
    assign gbyp     = cfg2_ff[`CFG2_BYPASS_BIT];
    assign single   = cfg2_ff[`CFG2_SINGLE_BIT];
    assign slow     = cfg6_ff[`CFG6_SLOW_BIT];
    // out-of-table selections fall back to the 2.5 V input
    assign sel_chan = (tach_ff[`SEL_HI:`SEL_LO] > `CH_LAST) ?
                      `CH_V25 : tach_ff[`SEL_HI:`SEL_LO];

    // sample period minus one for a channel
    function automatic tick_t period(input chan_t ch, input logic sg);
        tick_t p;
        p = VOLT_T;
        if (sg) begin
            p = VOLT_T;
        end else if (ch == `CH_REMOTE1 || ch == `CH_REMOTE2) begin
            p = REMOTE_T;
        end else if (ch == `CH_LOCAL) begin
            p = LOCAL_T;
        end
        return p;
    endfunction

    seq_state_t state_ff;
    seq_state_t nxt_state;
    chan_t      chan_ff;
    chan_t      nxt_chan;
    tick_t      timer_ff;
    tick_t      nxt_timer;
    tick_t      cycle_ff;
    tick_t      nxt_cycle;
    tick_t      cycle_len;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    acc_t       acc_ff;
    acc_t       nxt_acc;
    acc_t       sum;
    logic       start_ff;
    logic       nxt_start;
    logic       rvalid_ff;
    logic       nxt_rvalid;
    chan_t      rchan_ff;
    chan_t      nxt_rchan;
    logic [9:0] rcode_ff;
    logic [9:0] nxt_rcode;
    logic [4:0] byp_ff;
    logic [4:0] nxt_byp;

    assign cycle_len = slow ? SLOW_T : CYCLE_T;
    assign sum       = acc_ff + {4'h0, ADC_CODE};

    // conversion sequencer
    always_comb begin
        nxt_state  = state_ff;
        nxt_chan   = chan_ff;
        nxt_timer  = timer_ff;
        nxt_cnt    = cnt_ff;
        nxt_acc    = acc_ff;
        nxt_start  = 1'b0;
        nxt_rvalid = 1'b0;
        nxt_rchan  = rchan_ff;
        nxt_rcode  = rcode_ff;
        // free-running pass timer, saturates instead of wrapping
        nxt_cycle  = (cycle_ff == '1) ? cycle_ff : cycle_ff + 23'h000001;
        unique case (state_ff)
            SEQ_START: begin
                nxt_chan  = single ? sel_chan : chan_ff;
                nxt_timer = period(nxt_chan, single);
                nxt_start = 1'b1;
                nxt_state = SEQ_SAMPLE;
            end
            SEQ_SAMPLE: begin
                if (timer_ff != 23'h000000) begin
                    nxt_timer = timer_ff - 23'h000001;
                end else if (avg_off || single || cnt_ff == `AVG_LAST) begin
                    // last sample of the channel hands over a result
                    nxt_rvalid = 1'b1;
                    nxt_rchan  = chan_ff;
                    nxt_rcode  = (avg_off || single) ? ADC_CODE : sum[13:`AVG_SHIFT];
                    nxt_acc    = '0;
                    nxt_cnt    = 4'h0;
                    nxt_state  = SEQ_START;
                    if (single) begin
                        nxt_chan = sel_chan;
                    end else if (chan_ff == `CH_LAST) begin
                        nxt_chan = `CH_V25;
                        if (avg_off) begin
                            nxt_cycle = '0;
                        end else begin
                            nxt_state = SEQ_GAP;
                        end
                    end else begin
                        nxt_chan = chan_ff + 4'h1;
                    end
                end else begin
                    // not the last of sixteen: keep accumulating
                    nxt_acc   = sum;
                    nxt_cnt   = cnt_ff + 4'h1;
                    nxt_state = SEQ_START;
                end
            end
            SEQ_GAP: begin
                // pad the averaged pass out to the cycle length
                if (single || avg_off || cycle_ff >= cycle_len) begin
                    nxt_cycle = '0;
                    nxt_state = SEQ_START;
                end
            end
            // spare state code: restart the sequence
            default: begin
                nxt_state = SEQ_START;
            end
        endcase
    end

    // attenuator bypass per voltage input
    always_comb begin
        nxt_byp    = {5{gbyp}};
        nxt_byp[0] = gbyp | cfg4_ff[`CFG4_BYP_V25_BIT];
        nxt_byp[1] = gbyp | cfg4_ff[`CFG4_BYP_CORE_BIT];
        nxt_byp[3] = gbyp | cfg4_ff[`CFG4_BYP_V5_BIT];
        nxt_byp[4] = gbyp | cfg4_ff[`CFG4_BYP_V12_BIT];
    end

    // registered so the bypass pins come straight from flops
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            byp_ff <= 5'h00;
        end else begin
            byp_ff <= nxt_byp;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_ff  <= SEQ_START;
            chan_ff   <= `CH_V25;
            timer_ff  <= '0;
            cycle_ff  <= '0;
            cnt_ff    <= 4'h0;
            acc_ff    <= '0;
            start_ff  <= 1'b0;
            rvalid_ff <= 1'b0;
            rchan_ff  <= 4'h0;
            rcode_ff  <= 10'h000;
        end else begin
            state_ff  <= nxt_state;
            chan_ff   <= nxt_chan;
            timer_ff  <= nxt_timer;
            cycle_ff  <= nxt_cycle;
            cnt_ff    <= nxt_cnt;
            acc_ff    <= nxt_acc;
            start_ff  <= nxt_start;
            rvalid_ff <= nxt_rvalid;
            rchan_ff  <= nxt_rchan;
            rcode_ff  <= nxt_rcode;
        end
    end

    assign REG_RDATA     = rdata_ff;
    assign ADC_START     = start_ff;
    assign ADC_CHAN      = chan_ff;
    assign GLOBAL_ATTENUATOR_BYPASS_BYPASS   = byp_ff;
    assign RES_VALID     = rvalid_ff;
    assign RES_CHAN      = rchan_ff;
    assign RES_CODE      = rcode_ff;
    assign TACH_MIN_HIGH = tach_ff;

endmodule

// ---- hdl/adc_opt_defines.svh ----
/*
 * Constants for the ADC conversion option block: register offsets,
 * field positions, reset values, channel codes and timing figures.
 * Assumes inclusion by bare name from the package and the design.
 */
`ifndef ADC_OPT_DEFINES_SVH
`define ADC_OPT_DEFINES_SVH

`define ADDR_CFG6          8'h10
`define ADDR_TACH_SEL      8'h55
`define ADDR_CFG2          8'h73
`define ADDR_CFG4          8'h7D

`define CFG6_SLOW_BIT      7
`define CFG2_AVG_OFF_BIT   4
`define CFG2_BYPASS_BIT    5
`define CFG2_SINGLE_BIT    6
`define CFG4_BYP_V25_BIT   4
`define CFG4_BYP_CORE_BIT  5
`define CFG4_BYP_V5_BIT    6
`define CFG4_BYP_V12_BIT   7
`define SEL_HI             7
`define SEL_LO             4

`define REG_RESET          8'h00
`define UNMAPPED_READ      8'h00

`define CH_V25             4'h0
`define CH_CORE            4'h1
`define CH_SUPPLY          4'h2
`define CH_V5              4'h3
`define CH_V12             4'h4
`define CH_REMOTE1         4'h5
`define CH_LOCAL           4'h6
`define CH_REMOTE2         4'h7
`define CH_TERM            4'h8
`define CH_IMON            4'h9
`define CH_LAST            4'h9

`define AVG_LAST           4'hF
`define AVG_SHIFT          4

`define CLK_MHZ            20
`define T_VOLT_US          700
`define T_LOCAL_US         1300
`define T_REMOTE_US        7000
`define T_CYCLE_US         146500
`define T_SLOW_US          240000

`endif

// ---- hdl/adc_opt_pkg.sv ----
/*
 * Types for the ADC conversion option block.
 * Assumes the defines header sits beside it.
 */
`include "adc_opt_defines.svh"

package adc_opt_pkg;

    typedef enum logic [1:0] {
        SEQ_START,
        SEQ_SAMPLE,
        SEQ_GAP
    } seq_state_t;

    typedef logic [22:0] tick_t;
    typedef logic [3:0]  chan_t;
    typedef logic [13:0] acc_t;

endpackage

// ---- tb/adc_front_model.sv ----
/* converter stand-in: a code per channel from a bench offset.
   assumes the sequencer holds ADC_CHAN through a sample. */
`timescale 1ns/1ps
module adc_front_model (
    input  wire logic [3:0] chan,  // mux channel
    input  wire logic       start, // sample start
    input  wire logic [9:0] offs,  // bench offset
    output logic      [9:0] code   // converter result
);
    // scrambled while the input settles
    assign code = start ? ~(offs ^ {chan, 6'h00}) : offs ^ {chan, 6'h00};
endmodule

// ---- tb/adc_conversion_options_assertions.sv ----
/* port checker for the conversion option block.
   assumes a bound top module with VOLT_CYC of 8 or more. */
`timescale 1ns/1ps
module adc_opt_chk (
    input wire logic       SYS_CLK,      // clock
    input wire logic       RST_N,        // reset, low
    input wire logic [7:0] REG_ADDR,     // offset
    input wire logic [7:0] REG_WDATA,    // write data
    input wire logic       REG_WR,       // write strobe
    input wire logic       REG_RD,       // read strobe
    input wire logic [7:0] REG_RDATA,    // read data
    input wire logic       ADC_START,    // sample start
    input wire logic [3:0] ADC_CHAN,     // mux channel
    input wire logic [4:0] GLOBAL_ATTENUATOR_BYPASS_BYPASS,  // bypass
    input wire logic       RES_VALID,    // result strobe
    input wire logic [7:0] TACH_MIN_HIGH // fan limit
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    a_start_gap: assert property (ADC_START |=> !ADC_START [*8])
        else $error("start too soon");
    a_chan_hold: assert property (ADC_START |=> $stable(ADC_CHAN) [*7])
        else $error("channel moved in sample");
    a_valid_gap: assert property (RES_VALID |=> !RES_VALID [*8])
        else $error("result too soon");
    a_chan_range: assert property (ADC_START |-> ADC_CHAN <= 4'h9)
        else $error("channel out of range");
    a_global_byp: assert property (REG_WR && REG_ADDR == 8'h73 && REG_WDATA[5] |=> ##1 GLOBAL_ATTENUATOR_BYPASS_BYPASS == 5'h1F)
        else $error("global bypass missing");
    a_single_byp: assert property (REG_WR && REG_ADDR == 8'h7D && REG_WDATA[7] |=> ##1 GLOBAL_ATTENUATOR_BYPASS_BYPASS[4])
        else $error("12V bypass missing");
    a_tach_share: assert property (REG_WR && REG_ADDR == 8'h55 |=> TACH_MIN_HIGH == $past(REG_WDATA))
        else $error("fan limit not shared");
    a_sel_read: assert property (REG_RD && REG_ADDR == 8'h55 |=> REG_RDATA == $past(TACH_MIN_HIGH))
        else $error("select read wrong");
    a_reset_zero: assert property ($rose(RST_N) |-> TACH_MIN_HIGH == 8'h00 && GLOBAL_ATTENUATOR_BYPASS_BYPASS == 5'h00)
        else $error("reset value wrong");
    cover property (RES_VALID);
    cover property (ADC_START && ADC_CHAN == 4'h7);
    cover property (REG_WR && REG_ADDR == 8'h10 && REG_WDATA[7]);
endmodule
bind adc_conversion_options adc_opt_chk adc_opt_chk_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .ADC_START(ADC_START), .ADC_CHAN(ADC_CHAN),
    .GLOBAL_ATTENUATOR_BYPASS_BYPASS(GLOBAL_ATTENUATOR_BYPASS_BYPASS), .RES_VALID(RES_VALID), .TACH_MIN_HIGH(TACH_MIN_HIGH));

// ---- tb/tb_adc_conversion_options.sv ----
/* self-checking bench for the conversion option block.
   assumes shortened sample and cycle parameters. */
`timescale 1ns/1ps
module tb_adc_conversion_options;
    localparam int VC = 8, LC = 14, RC = 20, CC = 2500, SC = 3000;
    logic SYS_CLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, a2, a4;
    logic [7:0] regs [4] = '{8'h10, 8'h55, 8'h73, 8'h7D};
    logic [31:0] lfsr = 32'hE1660B6C;
    logic [9:0] offs = 10'h000;
    logic [9:0] ADC_CODE, RES_CODE;
    logic [7:0] REG_RDATA, TACH_MIN_HIGH;
    logic [4:0] GLOBAL_ATTENUATOR_BYPASS_BYPASS;
    logic [3:0] ADC_CHAN, RES_CHAN, sel, prv;
    logic ADC_START, RES_VALID, slow;
    int failures = 0, n_checks = 0, mode = 0, skip = 0, cyc = 0, gap = 0, t0 = 0;
    adc_conversion_options #(.VOLT_CYC(VC), .LOCAL_CYC(LC), .REMOTE_CYC(RC), .CYCLE_CYC(CC), .SLOW_CYC(SC))
        adc_conversion_options_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .ADC_CODE(ADC_CODE), .ADC_START(ADC_START), .ADC_CHAN(ADC_CHAN), .GLOBAL_ATTENUATOR_BYPASS_BYPASS(GLOBAL_ATTENUATOR_BYPASS_BYPASS),
        .RES_VALID(RES_VALID), .RES_CHAN(RES_CHAN), .RES_CODE(RES_CODE), .TACH_MIN_HIGH(TACH_MIN_HIGH));
    adc_front_model adc_front_model_i (.chan(ADC_CHAN), .start(ADC_START), .offs(offs), .code(ADC_CODE));
    always #25 SYS_CLK = ~SYS_CLK;
    function logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge SYS_CLK) {REG_ADDR, REG_WDATA, REG_WR} = {a, d, 1'b1};
        @(negedge SYS_CLK) REG_WR = 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge SYS_CLK) {REG_ADDR, REG_RD} = {a, 1'b1};
        @(negedge SYS_CLK) REG_RD = 0;
        @(negedge SYS_CLK) check(REG_RDATA, exp);
    endtask
    function automatic logic [4:0] exp_byp(logic [7:0] c2, logic [7:0] c4);
        logic g;
        g = c2[5];
        return {g | c4[7], g | c4[6], g, g | c4[5], g | c4[4]};
    endfunction
    function automatic int per(logic [3:0] ch);
        return (ch == 4'h5 || ch == 4'h7) ? RC : (ch == 4'h6) ? LC : VC;
    endfunction
    task stop_test;
        if (failures == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // result monitor
    always @(posedge SYS_CLK) begin
        cyc++;
        gap++;
        if (RST_N && RES_VALID) begin
            if (skip > 0) skip--;
            else if (mode > 0) begin
                check(RES_CODE, offs ^ {RES_CHAN, 6'h00});
                if (mode == 2) check({RES_CHAN, 28'(gap)}, {sel, 28'(VC + 1)});
                if (mode != 2) check(RES_CHAN, (prv == 4'h9) ? 4'h0 : prv + 4'h1);
                if (mode == 1) check(gap, per(RES_CHAN) + 1);
                if (mode == 3 && RES_CHAN != 4'h0) check(gap, 16 * (per(RES_CHAN) + 1));
                if (mode == 3 && RES_CHAN == 4'h0 && t0 > 0) check(cyc - t0, slow ? SC : CC);
                if (RES_CHAN == 4'h0) t0 = cyc;
            end
            prv = RES_CHAN;
            gap = 0;
        end
    end
    initial begin
        #(40000 * 50);
        failures++;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge SYS_CLK);
        @(negedge SYS_CLK) RST_N = 1;
        foreach (regs[i]) rd(regs[i], 8'h00);
        for (int i = 0; i < 8; i++) begin
            a2 = rnd();
            a4 = rnd();
            wr(8'h73, a2);
            wr(8'h7D, a4);
            wr(8'h00, 8'hFF);
            rd(8'h73, a2);
            rd(8'h7D, a4);
            rd(8'h00, 8'h00);
            check(GLOBAL_ATTENUATOR_BYPASS_BYPASS, exp_byp(a2, a4));
        end
        a2 = rnd();
        offs = {a2, 2'b11};
        wr(8'h7D, 8'h00);
        wr(8'h73, 8'h10);
        {mode, skip} = {32'd1, 32'd2};
        repeat (300) @(negedge SYS_CLK);
        for (int i = 0; i < 10; i++) begin
            mode = 0;
            sel = 4'(i);
            a4 = rnd();
            wr(8'h55, {sel, a4[3:0]});
            check(TACH_MIN_HIGH, {sel, a4[3:0]});
            wr(8'h73, 8'h40);
            {mode, skip} = {32'd2, 32'd2};
            repeat (50) @(negedge SYS_CLK);
        end
        for (int s = 0; s < 2; s++) begin
            mode = 0;
            slow = s[0];
            wr(8'h10, {slow, 7'h00});
            wr(8'h73, 8'h00);
            {mode, skip, t0} = {32'd3, 32'd11, 32'd0};
            repeat (4 * (slow ? SC : CC)) @(negedge SYS_CLK);
        end
        stop_test;
    end
endmodule
